// >>> logic/rc_core.v
/*
 * Execution core: four-phase sequencer, fetch/execute pipeline,
 * decoder, file map, call stack and APB control/observation port.
 * Assumes program memory answers imem_data within three clocks of
 * an imem_addr change, and that all inputs are synchronous to sys_clk.
 */
`timescale 1ns/100ps
`include "rc_defines.vh"
module rc_core #(
	parameter PROG_AW = 10,
	parameter STK_DEPTH = 8,
	parameter STK_AW = 3
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	input wire clk_en,
	// Device pins
	input wire external_reset_pin_n,
	output reg cycle_rate_output,
	// Instruction bus
	output wire [PROG_AW-1:0] imem_addr,
	input wire [`RC_IW-1:0] imem_data,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [1:0] q_q;
	reg [`RC_PCW-1:0] pc_q;
	reg [`RC_IW-1:0] fetch_q;
	reg [`RC_IW-1:0] ir_q;
	reg flush_q;
	reg hold_q;
	reg [7:0] w_q;
	reg [7:0] status_q;
	reg [7:0] fsr_q;
	reg [4:0] pclath_q;
	reg [7:0] opnd_q;
	reg [4:0] ctrl_q;
	reg [STK_AW-1:0] sp_q;
	reg [`RC_PCW-1:0] stk_q [0:STK_DEPTH-1];

	wire run = clk_en & ctrl_q[`RC_CTRL_RUN];
	wire pin_rst = ctrl_q[`RC_CTRL_PINRST] & ~external_reset_pin_n;
	wire ph1 = (q_q == `RC_Q1);
	wire ph2 = (q_q == `RC_Q2);
	wire ph3 = (q_q == `RC_Q3);
	wire ph4 = (q_q == `RC_Q4);
	wire [1:0] q_nxt = q_q + 2'h1;
	wire [1:0] osc_sel = ctrl_q[`RC_CTRL_OSC_HI:`RC_CTRL_OSC_LO];

	// Wraps above the implemented program space
	assign imem_addr = pc_q[PROG_AW-1:0];

	// ----------------------------------------
	// Decoder
	// ----------------------------------------
	reg [3:0] alu_op;
	reg use_lit;
	reg wr_f;
	reg wr_w;
	reg aff_z;
	reg aff_c;
	reg aff_dc;
	reg skz;
	reg btst;
	reg jmp;
	reg call;
	reg ret;

	wire d_bit = ir_q[7];

	always @* begin
		alu_op = `RC_OP_PASSB;
		use_lit = 1'b0;
		wr_f = 1'b0;
		wr_w = 1'b0;
		aff_z = 1'b0;
		aff_c = 1'b0;
		aff_dc = 1'b0;
		skz = 1'b0;
		btst = 1'b0;
		jmp = 1'b0;
		call = 1'b0;
		ret = 1'b0;
		case (ir_q[13:12])
			2'h0: begin
				wr_f = d_bit;
				wr_w = ~d_bit;
				case (ir_q[11:8])
					4'h0: begin
						alu_op = `RC_OP_PASSA;
						wr_w = 1'b0;
						ret = ~d_bit & ((ir_q[6:0] == `RC_RET) | (ir_q[6:0] == `RC_RETIE));
					end
					4'h1: begin
						alu_op = `RC_OP_ZERO;
						aff_z = 1'b1;
					end
					4'h2: begin
						alu_op = `RC_OP_SUB;
						aff_z = 1'b1;
						aff_c = 1'b1;
						aff_dc = 1'b1;
					end
					4'h3: begin
						alu_op = `RC_OP_DEC;
						aff_z = 1'b1;
					end
					4'h4: begin
						alu_op = `RC_OP_OR;
						aff_z = 1'b1;
					end
					4'h5: begin
						alu_op = `RC_OP_AND;
						aff_z = 1'b1;
					end
					4'h6: begin
						alu_op = `RC_OP_XOR;
						aff_z = 1'b1;
					end
					4'h7: begin
						alu_op = `RC_OP_ADD;
						aff_z = 1'b1;
						aff_c = 1'b1;
						aff_dc = 1'b1;
					end
					4'h8: begin
						aff_z = 1'b1;
					end
					4'h9: begin
						alu_op = `RC_OP_COM;
						aff_z = 1'b1;
					end
					4'ha: begin
						alu_op = `RC_OP_INC;
						aff_z = 1'b1;
					end
					4'hb: begin
						alu_op = `RC_OP_DEC;
						skz = 1'b1;
					end
					4'hc: begin
						alu_op = `RC_OP_RR;
						aff_c = 1'b1;
					end
					4'hd: begin
						alu_op = `RC_OP_RL;
						aff_c = 1'b1;
					end
					4'he: alu_op = `RC_OP_SWAP;
					default: begin
						alu_op = `RC_OP_INC;
						skz = 1'b1;
					end
				endcase
			end
			2'h1: begin
				case (ir_q[11:10])
					2'h0: begin
						alu_op = `RC_OP_BCLR;
						wr_f = 1'b1;
					end
					2'h1: begin
						alu_op = `RC_OP_BSET;
						wr_f = 1'b1;
					end
					default: btst = 1'b1;
				endcase
			end
			2'h2: begin
				jmp = 1'b1;
				call = ~ir_q[11];
			end
			default: begin
				use_lit = 1'b1;
				wr_w = 1'b1;
				aff_z = 1'b1;
				case (ir_q[11:8])
					4'h8: alu_op = `RC_OP_OR;
					4'h9: alu_op = `RC_OP_AND;
					4'ha: alu_op = `RC_OP_XOR;
					4'hc, 4'hd: begin
						alu_op = `RC_OP_SUB;
						aff_c = 1'b1;
						aff_dc = 1'b1;
					end
					4'he, 4'hf: begin
						alu_op = `RC_OP_ADD;
						aff_c = 1'b1;
						aff_dc = 1'b1;
					end
					default: begin
						// Move and return-with-literal leave flags alone
						alu_op = `RC_OP_PASSB;
						aff_z = 1'b0;
						ret = ir_q[10];
					end
				endcase
			end
		endcase
	end

	// ----------------------------------------
	// File addressing
	// ----------------------------------------
	// Address zero goes through the pointer; pointer zero reads 0
	wire [7:0] fa = (ir_q[6:0] == `RC_F_INDF) ?
		fsr_q : {status_q[`RC_ST_RP0], ir_q[6:0]};
	wire [6:0] fr = fa[6:0];
	reg ram_hit;
	reg [6:0] ram_idx;
	reg [7:0] file_rd;
	wire [7:0] ram_rd;

	always @* begin
		ram_hit = 1'b0;
		ram_idx = fr - `RC_GPR_LO;
		if (!fa[7] && fr >= `RC_GPR_LO) begin
			ram_hit = 1'b1;
		end else if (fa[7] && fr >= `RC_COMMON_LO) begin
			ram_hit = 1'b1;
		end else if (fa[7] && fr >= `RC_GPR_LO && fr <= `RC_B1_HI) begin
			ram_hit = 1'b1;
			ram_idx = fr + `RC_B1_OFS;
		end
	end

	always @* begin
		case (fr)
			`RC_F_PCL: file_rd = pc_q[7:0];
			`RC_F_STATUS: file_rd = status_q;
			`RC_F_FSR: file_rd = fsr_q;
			`RC_F_PCLATH: file_rd = {3'h0, pclath_q};
			default: file_rd = ram_hit ? ram_rd : 8'h00;
		endcase
	end

	// ----------------------------------------
	// ALU and result
	// ----------------------------------------
	wire [7:0] alu_b = use_lit ? ir_q[7:0] : opnd_q;
	wire [7:0] alu_res;
	wire alu_c;
	wire alu_dc;
	wire res_zero = (alu_res == 8'h00);
	wire skip = (skz & res_zero) | (btst & (opnd_q[ir_q[9:7]] == ir_q[10]));
	wire wr_pcl = wr_f & (fr == `RC_F_PCL);
	wire branch = jmp | ret | wr_pcl;
	reg [7:0] st_d;

	rc_alu u_alu (
		.a(w_q),
		.b(alu_b),
		.op(alu_op),
		.bsel(ir_q[9:7]),
		.c_in(status_q[`RC_ST_C]),
		.res(alu_res),
		.c_out(alu_c),
		.dc_out(alu_dc)
	);

	always @* begin
		st_d = status_q;
		if (wr_f && fr == `RC_F_STATUS) begin
			st_d = {alu_res[7:5], status_q[4:3], alu_res[2:0]};
		end
		// Flag results win over a direct write of the same bits
		if (aff_c) begin
			st_d[`RC_ST_C] = alu_c;
		end
		if (aff_dc) begin
			st_d[`RC_ST_DC] = alu_dc;
		end
		if (aff_z) begin
			st_d[`RC_ST_Z] = res_zero;
		end
	end

	// Read in phase two, written in phase four
	rc_ram #(
		.AW(7),
		.DW(8)
	) u_ram (
		.sys_clk(sys_clk),
		.re(run & ph2 & ~pin_rst),
		.we(run & ph4 & ~pin_rst & wr_f & ram_hit),
		.addr(ram_idx),
		.wdata(alu_res),
		.rdata_q(ram_rd)
	);

	// ----------------------------------------
	// Sequencer and pipeline
	// ----------------------------------------
	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			q_q <= `RC_Q1;
			pc_q <= 13'h0000;
			fetch_q <= `RC_NOP;
			ir_q <= `RC_NOP;
			flush_q <= 1'b1;
			hold_q <= 1'b1;
			w_q <= 8'h00;
			status_q <= `RC_STATUS_RST;
			fsr_q <= 8'h00;
			pclath_q <= 5'h00;
			opnd_q <= 8'h00;
			sp_q <= {STK_AW{1'b0}};
			cycle_rate_output <= 1'b0;
		end else if (clk_en && pin_rst) begin
			q_q <= `RC_Q1;
			pc_q <= 13'h0000;
			fetch_q <= `RC_NOP;
			ir_q <= `RC_NOP;
			flush_q <= 1'b1;
			hold_q <= 1'b1;
			w_q <= 8'h00;
			status_q <= `RC_STATUS_RST;
			fsr_q <= 8'h00;
			pclath_q <= 5'h00;
			opnd_q <= 8'h00;
			sp_q <= {STK_AW{1'b0}};
			cycle_rate_output <= 1'b0;
		end else if (run) begin
			q_q <= q_nxt;
			// High for the second half of each cycle: a quarter of the clock rate
			cycle_rate_output <= ctrl_q[`RC_CTRL_CROEN] & q_nxt[1] &
				((osc_sel == `RC_OSC_EXTERNAL_RC_OSCILLATOR_MODE) | (osc_sel == `RC_OSC_INTERNAL_RC_OSCILLATOR_MODE));
			if (ph1) begin
				ir_q <= flush_q ? `RC_NOP : fetch_q;
				flush_q <= 1'b0;
				hold_q <= 1'b0;
				if (!hold_q) begin
					pc_q <= pc_q + 13'h0001;
				end
			end
			if (ph3) begin
				opnd_q <= file_rd;
			end
			if (ph4) begin
				fetch_q <= imem_data;
				status_q <= st_d;
				if (wr_w) begin
					w_q <= alu_res;
				end
				if (wr_f && fr == `RC_F_FSR) begin
					fsr_q <= alu_res;
				end
				if (wr_f && fr == `RC_F_PCLATH) begin
					pclath_q <= alu_res[4:0];
				end
				if (ret) begin
					sp_q <= sp_q - 1'b1;
					pc_q <= stk_q[sp_q - 1'b1];
				end else if (jmp) begin
					pc_q <= {pclath_q[4:3], ir_q[10:0]};
				end else if (wr_pcl) begin
					pc_q <= {pclath_q, alu_res};
				end
				if (call) begin
					sp_q <= sp_q + 1'b1;
				end
				// Branch refetches at the target; skip only drops the fetched word
				flush_q <= branch | skip;
				hold_q <= branch;
			end
		end
	end

	// Return stack holds no reset value; it is only read after a push
	always @(posedge sys_clk) begin
		if (run && !pin_rst && ph4 && call) begin
			stk_q[sp_q] <= pc_q;
		end
	end

	// ----------------------------------------
	// APB slave, no wait states
	// ----------------------------------------
	wire acc = psel & penable & pready;
	wire mapped = (paddr == `RC_A_CTRL) | (paddr == `RC_A_PC) |
		(paddr == `RC_A_CORE) | (paddr == `RC_A_IR);
	reg [31:0] rd_d;

	always @* begin
		case (paddr)
			`RC_A_CTRL: rd_d = {27'h000_0000, ctrl_q};
			`RC_A_PC: rd_d = {19'h0_0000, pc_q};
			`RC_A_CORE: rd_d = {16'h0000, status_q, w_q};
			`RC_A_IR: rd_d = {18'h0_0000, ir_q};
			default: rd_d = 32'h0000_0000;
		endcase
	end

	always @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= `RC_CTRL_RST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~mapped;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_d;
			end
			if (acc && pwrite && paddr == `RC_A_CTRL) begin
				ctrl_q <= pwdata[4:0];
			end
		end
	end

endmodule

// >>> logic/rc_defines.vh
/*
 * Constants of the 8-bit core: phases, file map, ALU codes, APB map.
 * Assumes inclusion by bare name from the design files under logic/.
 */
`ifndef RC_DEFINES_VH
`define RC_DEFINES_VH
// Contract
// - One whole 14-bit instruction word is fetched from program memory per cycle.
// - Fetch of the next instruction overlaps execution of the current one.
// - All 35 instructions take one instruction cycle, branches excepted.
// - ALU is 8 bits: add, subtract, shift and logic between accumulator and file.
// - Arithmetic operands and results are two's complement.
// - Two-operand ops use the accumulator and a file location or literal.
// - Single-operand ops work on the accumulator or a file location.
// - Accumulator is an 8-bit register with no data-memory address.
// - ALU updates carry, nibble carry and zero flags as the instruction says.
// - In subtraction carry is the borrow, nibble carry the low-nibble borrow; the code sets each high when no borrow occurs.
// - Special registers, program counter included, sit in data-memory space.
// - Any operation works on any register, direct or indirect.
// - 128 bytes of data RAM; program space 1K or 2K words by variant.
// - In RC oscillator modes the cycle-rate output runs at a quarter clock.
// - With the reset pin function on, a low pin holds the core in reset.
// - Clock divides into four phases; the program counter advances in phase one.
// - A program counter change costs two cycles; the fetched word is flushed.
// - Operand read happens in phase two, destination write in phase four.

// ----------------------------------------
// Widths and phases
// ----------------------------------------
`define RC_IW 14
`define RC_DW 8
`define RC_PCW 13
`define RC_Q1 2'h0
`define RC_Q2 2'h1
`define RC_Q3 2'h2
`define RC_Q4 2'h3
`define RC_NOP 14'h0000

// ----------------------------------------
// File map and status layout
// ----------------------------------------
`define RC_F_INDF 7'h00
`define RC_F_PCL 7'h02
`define RC_F_STATUS 7'h03
`define RC_F_FSR 7'h04
`define RC_F_PCLATH 7'h0a
`define RC_GPR_LO 7'h20
`define RC_B1_HI 7'h3f
`define RC_COMMON_LO 7'h70
`define RC_B1_OFS 7'h40
`define RC_ST_C 0
`define RC_ST_DC 1
`define RC_ST_Z 2
`define RC_ST_RP0 5
`define RC_STATUS_RST 8'h18
`define RC_RET 7'h08
`define RC_RETIE 7'h09

// ----------------------------------------
// ALU operation codes
// ----------------------------------------
`define RC_OP_ADD 4'h0
`define RC_OP_SUB 4'h1
`define RC_OP_AND 4'h2
`define RC_OP_OR 4'h3
`define RC_OP_XOR 4'h4
`define RC_OP_PASSA 4'h5
`define RC_OP_PASSB 4'h6
`define RC_OP_ZERO 4'h7
`define RC_OP_COM 4'h8
`define RC_OP_INC 4'h9
`define RC_OP_DEC 4'ha
`define RC_OP_RR 4'hb
`define RC_OP_RL 4'hc
`define RC_OP_SWAP 4'hd
`define RC_OP_BCLR 4'he
`define RC_OP_BSET 4'hf

// ----------------------------------------
// APB map and control fields
// ----------------------------------------
`define RC_A_CTRL 12'h000
`define RC_A_PC 12'h004
`define RC_A_CORE 12'h008
`define RC_A_IR 12'h00c
`define RC_CTRL_RUN 0
`define RC_CTRL_PINRST 1
`define RC_CTRL_CROEN 2
`define RC_CTRL_OSC_LO 3
`define RC_CTRL_OSC_HI 4
`define RC_CTRL_RST 5'h03
`define RC_OSC_EXTERNAL_RC_OSCILLATOR_MODE 2'h2
`define RC_OSC_INTERNAL_RC_OSCILLATOR_MODE 2'h3
`endif

// >>> logic/rc_ram.v
/*
 * Data RAM of the core, 128 bytes, registered read port.
 * Assumes one clock and a single read or write per phase.
 */
`timescale 1ns/100ps
module rc_ram #(
	parameter AW = 7,
	parameter DW = 8
) (
	// Clock
	input wire sys_clk,
	// Access
	input wire re,
	input wire we,
	input wire [AW-1:0] addr,
	input wire [DW-1:0] wdata,
	output reg [DW-1:0] rdata_q
);

	reg [DW-1:0] mem [0:(1<<AW)-1];

	always @(posedge sys_clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata_q <= mem[addr];
		end
	end

endmodule

// >>> logic/rc_alu.v
/*
 * Combinational 8-bit ALU with carry and nibble-carry outputs.
 * Assumes the core picks operands and decides which flags to keep.
 */
`timescale 1ns/100ps
`include "rc_defines.vh"
module rc_alu (
	// Operands
	input wire [7:0] a,
	input wire [7:0] b,
	input wire [3:0] op,
	input wire [2:0] bsel,
	input wire c_in,
	// Results
	output reg [7:0] res,
	output reg c_out,
	output reg dc_out
);

	wire [8:0] add_s = {1'b0, a} + {1'b0, b};
	wire [4:0] add_n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
	// Two's complement b - a; carry out high means no borrow
	wire [8:0] sub_s = {1'b0, b} + {1'b0, ~a} + 9'h001;
	wire [4:0] sub_n = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
	wire [7:0] bmask = 8'h01 << bsel;

	always @* begin
		res = b;
		c_out = c_in;
		dc_out = 1'b0;
		case (op)
			`RC_OP_ADD: begin
				res = add_s[7:0];
				c_out = add_s[8];
				dc_out = add_n[4];
			end
			`RC_OP_SUB: begin
				res = sub_s[7:0];
				c_out = sub_s[8];
				dc_out = sub_n[4];
			end
			`RC_OP_AND: res = a & b;
			`RC_OP_OR: res = a | b;
			`RC_OP_XOR: res = a ^ b;
			`RC_OP_PASSA: res = a;
			`RC_OP_PASSB: res = b;
			`RC_OP_ZERO: res = 8'h00;
			`RC_OP_COM: res = ~b;
			`RC_OP_INC: res = b + 8'h01;
			`RC_OP_DEC: res = b - 8'h01;
			`RC_OP_RR: begin
				res = {c_in, b[7:1]};
				c_out = b[0];
			end
			`RC_OP_RL: begin
				res = {b[6:0], c_in};
				c_out = b[7];
			end
			`RC_OP_SWAP: res = {b[3:0], b[7:4]};
			`RC_OP_BCLR: res = b & ~bmask;
			`RC_OP_BSET: res = b | bmask;
			default: res = b;
		endcase
	end

endmodule

// >>> sim/rc_core_assertions.sv
/* Port checker for rc_core: fetch pacing, pin reset, cycle-rate output, APB.
   Assumes clk_en high and the reset pin function left enabled. */
`timescale 1ns/100ps
`include "rc_defines.vh"
module rc_core_chk #(
	parameter PROG_AW = 10
) (
	// Clock and reset
	input wire sys_clk,
	input wire reset,
	input wire clk_en,
	// Pins
	input wire external_reset_pin_n,
	input wire cycle_rate_output,
	// Instruction bus
	input wire [PROG_AW-1:0] imem_addr,
	input wire [`RC_IW-1:0] imem_data,
	// APB
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	// ----
	// Core sequencing
	// ----
	sequence cr_hi2;
		cycle_rate_output ##1 cycle_rate_output;
	endsequence
	sequence cr_lo2;
		!cycle_rate_output ##1 !cycle_rate_output;
	endsequence
	sequence addr_hold;
		$stable(imem_addr) [*2];
	endsequence

	crout_period_a: assert property (disable iff (reset || !external_reset_pin_n)
		$rose(cycle_rate_output) |-> cr_hi2 ##1 cr_lo2 ##1 cycle_rate_output)
		else $error("cycle-rate output not a four clock period");
	fetch_gap_a: assert property (disable iff (reset || !external_reset_pin_n)
		$changed(imem_addr) |=> addr_hold)
		else $error("fetch address moved too soon");
	fetch_alive_a: assert property (disable iff (reset || !external_reset_pin_n)
		$changed(imem_addr) |-> ##[1:8] $changed(imem_addr))
		else $error("fetch stalled");
	pin_hold_a: assert property (!external_reset_pin_n |=>
		imem_addr == 0 && !cycle_rate_output)
		else $error("core not held by reset pin");

	// ----
	// APB port
	// ----
	apb_ready_a: assert property (psel && !penable && clk_en |=> pready)
		else $error("no ready after setup");
	apb_once_a: assert property ((!psel || penable) |=> !pready)
		else $error("ready outside first access cycle");
	apb_map_a: assert property (pready && paddr[1:0] == 2'b00 |->
		pslverr == (paddr > `RC_A_IR))
		else $error("error response does not match map");
	err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	err_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule

bind rc_core rc_core_chk #(.PROG_AW(PROG_AW)) u_chk (.sys_clk, .reset, .clk_en,
	.external_reset_pin_n, .cycle_rate_output, .imem_addr, .imem_data, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

// >>> sim/rc_prog_mem.sv
/* Program memory model on the instruction bus.
   Assumes the bench loads mem while the core is held in reset. */
`timescale 1ns/100ps
module rc_prog_mem #(
	parameter AW = 10
) (
	// Clock
	input wire sys_clk,
	// Answer speed
	input wire slow,
	// Instruction bus
	input wire [AW-1:0] addr,
	output wire [13:0] data
);
	reg [13:0] mem [0:(1<<AW)-1];
	reg [AW-1:0] last_q;
	reg seen_q;
	reg tog_q;
	integer i;

	initial begin
		for (i = 0; i < (1 << AW); i = i + 1)
			mem[i] = 14'h0000;
		last_q = 0;
		seen_q = 1'b0;
		tog_q = 1'b0;
	end
	// Slow mode settles two clocks after a change; until then the bus flickers
	always @(posedge sys_clk) begin
		tog_q <= ~tog_q;
		last_q <= addr;
		seen_q <= (addr == last_q);
	end
	assign data = (!slow || (addr == last_q && seen_q)) ? mem[addr] : ~mem[addr] ^ {14{tog_q}};
endmodule

// >>> sim/risc_core_alu_datapath_test.sv
/* Self-checking bench for rc_core with a program memory model.
   Assumes clk_en held high; core state is read over APB. */
`timescale 1ns/100ps
`include "rc_defines.vh"
module risc_core_alu_datapath_test;
	reg sys_clk, reset, clk_en, external_reset_pin_n, slow;
	reg psel, penable, pwrite;
	reg [11:0] paddr;
	reg [31:0] pwdata, rd;
	reg err;
	wire cycle_rate_output, pready, pslverr;
	wire [9:0] imem_addr;
	wire [13:0] imem_data;
	wire [31:0] prdata;
	int n_fail, checks_done, cyc, n1, n2;
	// {first literal, opcode top, literal, status, accumulator}
	logic [39:0] tab [8] = '{40'h88_3e78_1f00, 40'h01_3c00_18ff, 40'h01_3c13_1b12,
		40'h05_3c05_1f00, 40'hf0_390f_1c00, 40'h30_3803_1833, 40'h5a_3aff_18a5,
		40'h7f_3e01_1a80};

	rc_core u_dut (.sys_clk, .reset, .clk_en, .external_reset_pin_n, .cycle_rate_output,
		.imem_addr, .imem_data, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	rc_prog_mem u_pm (.sys_clk, .slow, .addr(imem_addr), .data(imem_data));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	// ----
	// Shared tasks
	// ----
	task summarize;
		begin
			$display("checks=%0d mismatches=%0d", checks_done, n_fail);
			if (n_fail == 0 && checks_done > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		begin
			@(posedge sys_clk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= wr;
			paddr <= a;
			pwdata <= wd;
			@(posedge sys_clk);
			penable <= 1'b1;
			// Waits as long as the slave needs; only the hang guard ends it
			do begin
				@(posedge sys_clk);
			end while (pready !== 1'b1);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task hold;
		begin
			@(posedge sys_clk);
			external_reset_pin_n <= 1'b0;
			repeat (3) @(posedge sys_clk);
			chk({22'h0, imem_addr}, 32'h0000_0000);
		end
	endtask
	task go(input int cycles);
		begin
			external_reset_pin_n <= 1'b1;
			repeat (4 * cycles) @(posedge sys_clk);
		end
	endtask
	task core_is(input logic [7:0] st, input logic [7:0] w);
		begin
			apb(1'b0, `RC_A_CORE, 32'h0000_0000);
			chk(rd, {16'h0, st, w});
		end
	endtask
	task wait_addr(input logic [9:0] a, output int n);
		begin
			n = 0;
			do begin
				@(posedge sys_clk);
				n = n + 1;
			end while (imem_addr !== a && n < 40);
		end
	endtask
	task highs(output int h);
		begin
			h = 0;
			repeat (16) begin
				@(posedge sys_clk);
				h = h + (cycle_rate_output === 1'b1);
			end
		end
	endtask

	// ----
	// Scenarios
	// ----
	task t_regs;
		begin
			apb(1'b0, `RC_A_CTRL, 32'h0000_0000);
			chk(rd, {27'h0, `RC_CTRL_RST});
			apb(1'b0, 12'h010, 32'h0000_0000);
			chk({err, rd[30:0]}, 32'h8000_0000);
		end
	endtask
	task t_crout;
		int i;
		int h;
		begin
			apb(1'b1, `RC_A_CTRL, 32'h0000_0007);
			highs(h);
			chk(h, 0);
			// Both RC modes; the last leaves the output running
			for (i = 2; i < 4; i = i + 1) begin
				apb(1'b1, `RC_A_CTRL, {27'h0, i[1:0], 3'b111});
				apb(1'b0, `RC_A_CTRL, 32'h0000_0000);
				chk(rd, {27'h0, i[1:0], 3'b111});
				highs(h);
				chk(h, 8);
			end
		end
	endtask
	task t_alu_lit;
		int i;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				slow <= i[0];
				hold();
				u_pm.mem[0] = {6'h30, tab[i][39:32]};
				u_pm.mem[1] = tab[i][29:16];
				u_pm.mem[2] = 14'h2802;
				go(6);
				core_is(tab[i][15:8], tab[i][7:0]);
			end
		end
	endtask
	task t_file;
		begin
			hold();
			u_pm.mem[0] = 14'h3081;
			u_pm.mem[1] = 14'h00a0;
			u_pm.mem[2] = 14'h0da0;
			u_pm.mem[3] = 14'h3020;
			u_pm.mem[4] = 14'h0084;
			u_pm.mem[5] = 14'h0e80;
			u_pm.mem[6] = 14'h0a00;
			u_pm.mem[7] = 14'h2807;
			go(12);
			core_is(8'h19, 8'h21);
		end
	endtask
	task t_branch;
		begin
			hold();
			u_pm.mem[0] = 14'h3010;
			u_pm.mem[1] = 14'h2803;
			u_pm.mem[2] = 14'h3e40;
			u_pm.mem[3] = 14'h3e01;
			u_pm.mem[4] = 14'h2804;
			go(0);
			wait_addr(10'h001, n1);
			wait_addr(10'h002, n1);
			wait_addr(10'h004, n2);
			chk(n1, 4);
			chk(n2, 8);
			repeat (12) @(posedge sys_clk);
			core_is(8'h18, 8'h11);
		end
	endtask
	// Call, counted skip, bit test, literal return: each wrong path leaves another W
	task t_call;
		begin
			hold();
			u_pm.mem[0] = 14'h3002;
			u_pm.mem[1] = 14'h00a0;
			u_pm.mem[2] = 14'h2006;
			u_pm.mem[3] = 14'h3e10;
			u_pm.mem[4] = 14'h2804;
			u_pm.mem[6] = 14'h0ba0;
			u_pm.mem[7] = 14'h0ba0;
			u_pm.mem[8] = 14'h3455;
			u_pm.mem[9] = 14'h1d03;
			u_pm.mem[10] = 14'h3421;
			u_pm.mem[11] = 14'h3466;
			go(16);
			core_is(8'h18, 8'h31);
		end
	endtask

	// Hang guard, far above the few hundred clocks the run needs
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail = n_fail + 1;
			summarize();
		end
	end

	initial begin
		reset = 1'b1;
		clk_en = 1'b1;
		external_reset_pin_n = 1'b1;
		slow = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		n_fail = 0;
		checks_done = 0;
		cyc = 0;
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		t_regs();
		t_crout();
		t_alu_lit();
		t_file();
		t_branch();
		t_call();
		summarize();
	end
endmodule
